// ===== uart_defs.vh
// Register map, field positions and timing constants of the differential serial port
// Operation
// - Line control bit 7 switches offsets 0 and 1 to the baud divisor.
// - Divisor low byte at offset 0, high byte at offset 1.
// - Bit rate is reference clock over thirty-two times divisor.
// - Reference clock is 1.8432 MHz low setting, 7.3728 MHz high setting.
// - Line control bits 1:0 give character length minus five.
// - Line control bit 2 selects one or two stop bits.
// - Line control bits 3 to 6 control parity and break.
// - Line status bit 0 is high while a received character waits.
// - Line status bit 5 high when transmit holding register is empty.
// - Interrupt identification shows 4 for received data, else none pending.
// - In RS422 mode modem control bit 1 drives request-to-send direction.
// - In RS485 mode the driver turns on whenever transmit data is ready.
// - Modem control bit 3 gates the interrupt request output.
// - A jumper selects RS422 or RS485 direction control.
`ifndef UART_DEFS_VH
`define UART_DEFS_VH
`define ADDR_DATA 3'h0
`define ADDR_DIV_HIGH 3'h1
`define ADDR_IIR 3'h2
`define ADDR_LCR 3'h3
`define ADDR_MCR3 3'h4
`define ADDR_LSR 3'h5
`define LCR_DIV_SELECT 7
`define CHAR_LEN_BASE 4'h5
`define LCR_STOP 2
`define LCR_PAR_EN 3
`define LCR_PAR_EVEN 4
`define LCR_PAR_STICK 5
`define LCR_BREAK 6
`define MCR_RTS 1
`define MCR_GATE 3
`define LCR_RESET 8'h00
`define MCR_RESET 8'h00
`define DIV_RESET 16'h0000
`define IIR_RX_DATA 8'h04
`define IIR_NONE 8'h01
`define OVERSAMPLE 5'h1f
`define OVERSAMPLE_MID 5'h0f
`endif

// ===== uart_buf2.v
// Two-entry valid/ready buffer in the transmit data path
`timescale 1ns/10ps
module uart_buf2
#(
    parameter WIDTH = 8
)
(
    input wire i_core_clk,
    input wire i_rst_b,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:1];
    reg wr_ptr;
    reg rd_ptr;
    reg [1:0] count;
    wire push;
    wire pop;

    // Handshakes; full and empty come straight from the count
    assign o_in_ready = (count != 2'd2);
    assign o_out_valid = (count != 2'd0);
    assign o_out_data = mem[rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Pointers and occupancy count
    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'd0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop)
            begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop)
            begin
                count <= count + 2'd1;
            end
            else if (pop && !push)
            begin
                count <= count - 2'd1;
            end
        end
    end

    // Data array has no reset; only valid entries are read
    always @(posedge i_core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= i_in_data;
        end
    end
endmodule

// ===== uart_diff_port.v
// Differential serial port core with byte-wide register set
`timescale 1ns/10ps
`include "uart_defs.vh"
module uart_diff_port
(
    input wire i_core_clk,
    input wire i_rst_b,
    input wire [2:0] i_addr,
    input wire i_rd,
    input wire i_wr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    input wire i_ref_clk_en,
    input wire i_mode_rs485,
    input wire i_rx,
    output reg o_tx,
    output wire o_rts,
    output wire o_drv_en,
    output wire o_irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [7:0] lcr;
    reg [7:0] mcr;
    reg [15:0] divisor;
    reg [7:0] rx_hold;
    reg rx_ready;
    wire divisor_access_select = lcr[`LCR_DIV_SELECT];
    wire [3:0] char_len = {2'b00, lcr[1:0]} + `CHAR_LEN_BASE;
    wire tx_ready;
    wire tx_valid;
    wire [7:0] tx_data;
    reg tx_take;
    reg tx_busy;
    reg rx_done;
    reg [7:0] rx_byte;

    // Host writes; divisor access select reroutes offsets 0 and 1
    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            lcr <= `LCR_RESET;
            mcr <= `MCR_RESET;
            divisor <= `DIV_RESET;
        end
        else if (i_wr)
        begin
            if (i_addr == `ADDR_DATA && divisor_access_select)
            begin
                divisor[7:0] <= i_wdata;
            end
            if (i_addr == `ADDR_DIV_HIGH && divisor_access_select)
            begin
                divisor[15:8] <= i_wdata;
            end
            if (i_addr == `ADDR_LCR)
            begin
                lcr <= i_wdata;
            end
            if (i_addr == `ADDR_MCR3)
            begin
                mcr <= i_wdata;
            end
        end
    end

    // Data writes with divisor access clear feed the transmit buffer
    wire tx_push = i_wr && (i_addr == `ADDR_DATA) && !divisor_access_select;
    wire thr_empty = tx_ready && !tx_valid;

    uart_buf2 #(.WIDTH(8)) u_txbuf
    (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_in_valid(tx_push),
        .o_in_ready(tx_ready),
        .i_in_data(i_wdata),
        .o_out_valid(tx_valid),
        .i_out_ready(tx_take),
        .o_out_data(tx_data)
    );

    // Read mux; receive read pops the holding register
    wire rx_pop = i_rd && (i_addr == `ADDR_DATA) && !divisor_access_select;
    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_rdata <= 8'h00;
        end
        else if (i_rd)
        begin
            case (i_addr)
                `ADDR_DATA: o_rdata <= divisor_access_select ? divisor[7:0] : rx_hold;
                `ADDR_DIV_HIGH: o_rdata <= divisor_access_select ? divisor[15:8] : 8'h00;
                `ADDR_IIR: o_rdata <= rx_ready ? `IIR_RX_DATA : `IIR_NONE;
                `ADDR_LCR: o_rdata <= lcr;
                `ADDR_MCR3: o_rdata <= mcr;
                `ADDR_LSR: o_rdata <= {1'b0, thr_empty && !tx_busy, thr_empty, 4'h0,
                    rx_ready};
                default: o_rdata <= 8'h00;
            endcase
        end
    end

    // Receive flag: a new character wins over a same-cycle read
    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_ready <= 1'b0;
            rx_hold <= 8'h00;
        end
        else if (rx_done)
        begin
            rx_ready <= 1'b1;
            rx_hold <= rx_byte;
        end
        else if (rx_pop)
        begin
            rx_ready <= 1'b0;
        end
    end

    // Interrupt only while the gate output bit is set
    assign o_irq = rx_ready && mcr[`MCR_GATE];

    // ------------------------------------------------------------
    // Baud tick: reference enable divided by divisor, 32 ticks a bit
    // ------------------------------------------------------------
    // Reference enable pulses at 1.8432 or 7.3728 MHz per the rate jumper
    reg [15:0] div_cnt;
    reg tick;
    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            div_cnt <= 16'h0000;
            tick <= 1'b0;
        end
        else
        begin
            tick <= 1'b0;
            if (i_ref_clk_en)
            begin
                if (div_cnt + 16'h0001 >= divisor)
                begin
                    div_cnt <= 16'h0000;
                    tick <= 1'b1;
                end
                else
                begin
                    div_cnt <= div_cnt + 16'h0001;
                end
            end
        end
    end

    // Pin input synchroniser
    reg rx_s1;
    reg rx_s2;
    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end
        else
        begin
            rx_s1 <= i_rx;
            rx_s2 <= rx_s1;
        end
    end

    // ------------------------------------------------------------
    // Transmitter: 32 ticks per bit
    // ------------------------------------------------------------
    localparam TX_IDLE = 2'd0;
    localparam TX_DATA = 2'd1;
    localparam TX_PAR = 2'd2;
    localparam TX_STOP = 2'd3;
    reg [1:0] tx_state;
    reg [4:0] tx_sub;
    reg [3:0] tx_bit;
    reg [7:0] tx_shift;
    reg tx_parity;
    wire par_bit = lcr[`LCR_PAR_STICK] ? !lcr[`LCR_PAR_EVEN] : (tx_parity ^
        !lcr[`LCR_PAR_EVEN]);
    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tx_state <= TX_IDLE;
            tx_sub <= 5'h00;
            tx_bit <= 4'h0;
            tx_shift <= 8'h00;
            tx_parity <= 1'b0;
            tx_busy <= 1'b0;
            tx_take <= 1'b0;
            o_tx <= 1'b1;
        end
        else
        begin
            tx_take <= 1'b0;
            case (tx_state)
                TX_IDLE:
                begin
                    o_tx <= !lcr[`LCR_BREAK] ? 1'b1 : 1'b0;
                    if (tx_valid && !tx_take && tick)
                    begin
                        tx_take <= 1'b1;
                        tx_shift <= tx_data;
                        tx_parity <= 1'b0;
                        tx_busy <= 1'b1;
                        tx_sub <= 5'h00;
                        tx_bit <= 4'h0;
                        o_tx <= 1'b0;
                        tx_state <= TX_DATA;
                    end
                    else if (!tx_valid)
                    begin
                        tx_busy <= 1'b0;
                    end
                end
                TX_DATA, TX_PAR, TX_STOP:
                begin
                    if (tick)
                    begin
                        tx_sub <= tx_sub + 5'h01;
                        if (tx_sub == `OVERSAMPLE)
                        begin
                            tx_bit <= tx_bit + 4'h1;
                            if (tx_state == TX_DATA && tx_bit < char_len)
                            begin
                                o_tx <= tx_shift[0] & !lcr[`LCR_BREAK];
                                tx_parity <= tx_parity ^ tx_shift[0];
                                tx_shift <= {1'b0, tx_shift[7:1]};
                            end
                            else if (tx_state == TX_DATA && lcr[`LCR_PAR_EN])
                            begin
                                o_tx <= par_bit & !lcr[`LCR_BREAK];
                                tx_state <= TX_PAR;
                            end
                            else if (tx_state != TX_STOP)
                            begin
                                o_tx <= !lcr[`LCR_BREAK];
                                tx_bit <= 4'h0;
                                tx_state <= TX_STOP;
                            end
                            else if (tx_bit == {3'b000, lcr[`LCR_STOP]})
                            begin
                                tx_state <= TX_IDLE;
                            end
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // Direction: RTS in RS422, auto driver enable in RS485
    assign o_rts = mcr[`MCR_RTS];
    assign o_drv_en = i_mode_rs485 ? (tx_valid || tx_busy) : mcr[`MCR_RTS];

    // ------------------------------------------------------------
    // Receiver: samples mid-bit
    // ------------------------------------------------------------
    localparam RX_IDLE = 2'd0;
    localparam RX_BITS = 2'd1;
    localparam RX_STOP = 2'd2;
    reg [1:0] rx_state;
    reg [4:0] rx_sub;
    reg [3:0] rx_bit;
    wire [3:0] rx_frame = char_len + {3'b000, lcr[`LCR_PAR_EN]};
    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_state <= RX_IDLE;
            rx_sub <= 5'h00;
            rx_bit <= 4'h0;
            rx_byte <= 8'h00;
            rx_done <= 1'b0;
        end
        else
        begin
            rx_done <= 1'b0;
            case (rx_state)
                RX_IDLE:
                begin
                    if (tick && !rx_s2)
                    begin
                        rx_sub <= 5'h00;
                        rx_bit <= 4'h0;
                        rx_byte <= 8'h00;
                        rx_state <= RX_BITS;
                    end
                end
                RX_BITS:
                begin
                    if (tick)
                    begin
                        rx_sub <= rx_sub + 5'h01;
                        if (rx_sub == `OVERSAMPLE_MID)
                        begin
                            // Start bit glitch returns to idle
                            if (rx_bit == 4'h0 && rx_s2)
                            begin
                                rx_state <= RX_IDLE;
                            end
                            else if (rx_bit != 4'h0 && rx_bit <= char_len)
                            begin
                                rx_byte[rx_bit[2:0] - 3'd1] <= rx_s2;
                            end
                            rx_bit <= rx_bit + 4'h1;
                            if (rx_bit == rx_frame)
                            begin
                                rx_state <= RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP:
                begin
                    if (tick && rx_sub == `OVERSAMPLE_MID)
                    begin
                        rx_done <= 1'b1;
                        rx_state <= RX_IDLE;
                    end
                    else if (tick)
                    begin
                        rx_sub <= rx_sub + 5'h01;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end
endmodule

// ===== remote_node.sv
// Behavioural remote serial node on the far side of the line pins
`timescale 1ns/10ps
module remote_node
(
    input wire i_clk,
    input wire i_line,
    output logic o_line
);
    int bit_cyc = 32;
    int nbits = 8;
    int cyc = 0;
    int bad_stop = 0;
    int par_on = 0;
    int par_even = 0;
    int bad_par = 0;
    logic [7:0] got[$];
    int start_at[$];

    // Free cycle count, used to time frame starts
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
    end

    // Line rests at mark, as the bias holds it
    initial o_line = 1'b1;

    // Sample each bit mid-cell; a late or early rate shifts samples off
    initial forever
    begin : rx_frame
        logic [7:0] b;
        @(negedge i_line);
        start_at.push_back(cyc);
        b = 8'h00;
        repeat (bit_cyc / 2) @(posedge i_clk);
        for (int i = 0; i < nbits; i++)
        begin
            repeat (bit_cyc) @(posedge i_clk);
            b[i] = i_line;
        end
        // Parity cell sits between the last data bit and the stop bit
        if (par_on != 0)
        begin
            repeat (bit_cyc) @(posedge i_clk);
            if (i_line !== ((^b) ^ (par_even == 0)))
                bad_par++;
        end
        repeat (bit_cyc) @(posedge i_clk);
        if (!i_line)
            bad_stop++;
        got.push_back(b);
    end

    // One frame, least significant bit first
    task automatic send(input logic [7:0] b, input int stops);
        o_line <= 1'b0;
        repeat (bit_cyc) @(posedge i_clk);
        for (int i = 0; i < nbits; i++)
        begin
            o_line <= b[i];
            repeat (bit_cyc) @(posedge i_clk);
        end
        if (par_on != 0)
        begin
            o_line <= (^b) ^ (par_even == 0);
            repeat (bit_cyc) @(posedge i_clk);
        end
        o_line <= 1'b1;
        repeat (bit_cyc * stops) @(posedge i_clk);
    endtask
endmodule

// ===== uart_port_monitor.sv
// Port-level checker for the differential serial port
`timescale 1ns/10ps
module uart_port_monitor
(
    input wire i_core_clk,
    input wire i_rst_b,
    input wire [2:0] i_addr,
    input wire i_rd,
    input wire i_wr,
    input wire [7:0] i_wdata,
    input wire [7:0] o_rdata,
    input wire i_mode_rs485,
    input wire o_tx,
    input wire o_rts,
    input wire o_drv_en,
    input wire o_irq
);
    logic [7:0] lcr;
    logic [7:0] mcr;
    logic [7:0] dlo;

    // Shadow of host writes; divisor only while access select is set
    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            lcr <= 8'h00;
            mcr <= 8'h00;
            dlo <= 8'h00;
        end
        else if (i_wr)
        begin
            if (i_addr == 3'h3)
                lcr <= i_wdata;
            if (i_addr == 3'h4)
                mcr <= i_wdata;
            if (i_addr == 3'h0 && lcr[7])
                dlo <= i_wdata;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    property p_div_rb; i_rd && i_addr == 3'h0 && lcr[7] |=> o_rdata == dlo; endproperty
    a_div_rb: assert property (p_div_rb) else $error("divisor low readback");
    property p_lcr_rb; i_rd && i_addr == 3'h3 |=> o_rdata == lcr; endproperty
    a_lcr_rb: assert property (p_lcr_rb) else $error("line control readback");
    property p_rts; i_wr && i_addr == 3'h4 |=> o_rts == mcr[1]; endproperty
    a_rts: assert property (p_rts) else $error("rts not control bit 1");
    property p_iir; i_rd && i_addr == 3'h2 && o_irq |=> o_rdata == 8'h04; endproperty
    a_iir: assert property (p_iir) else $error("cause not rx data");
    property p_lsr; i_rd && i_addr == 3'h5 && o_irq |=> o_rdata[0]; endproperty
    a_lsr: assert property (p_lsr) else $error("rx ready flag low");
    property p_gate; o_irq |-> mcr[3]; endproperty
    a_gate: assert property (p_gate) else $error("irq while gate clear");
    property p_dir422; !i_mode_rs485 |-> o_drv_en == o_rts; endproperty
    a_dir422: assert property (p_dir422) else $error("driver not rts");
    property p_dir485; i_mode_rs485 && !o_tx |-> o_drv_en; endproperty
    a_dir485: assert property (p_dir485) else $error("driver off mid frame");
    property p_release; i_mode_rs485 && $fell(o_drv_en) |-> o_tx; endproperty
    a_release: assert property (p_release) else $error("driver freed early");
endmodule

bind uart_diff_port uart_port_monitor uart_port_monitor_inst (.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_mode_rs485(i_mode_rs485), .o_tx(o_tx), .o_rts(o_rts),
    .o_drv_en(o_drv_en), .o_irq(o_irq));

// ===== tb_differential_serial_port_uart.sv
// Self-checking bench for the differential serial port
`timescale 1ns/10ps
module tb_differential_serial_port_uart;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [2:0] i_addr = 3'h0;
    logic i_rd = 1'b0;
    logic i_wr = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    logic i_ref_clk_en = 1'b0;
    logic i_mode_rs485 = 1'b0;
    wire i_rx, o_tx, o_rts, o_drv_en, o_irq;
    wire [7:0] o_rdata;
    int err_count = 0;
    int checks = 0;
    int cyc_cnt = 0;
    int ref_per = 1;
    int ref_cnt = 0;
    logic [7:0] v, lcr, mcr, b0, b1, rb, mask;
    int div, nb, stops, gap, n0, par, pev;
    bit m485;

    uart_diff_port uart_diff_port_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .i_ref_clk_en(i_ref_clk_en), .i_mode_rs485(i_mode_rs485), .i_rx(i_rx),
        .o_tx(o_tx), .o_rts(o_rts), .o_drv_en(o_drv_en), .o_irq(o_irq));
    remote_node remote_node_inst (.i_clk(i_core_clk), .i_line(o_tx), .o_line(i_rx));

    always #12.5 i_core_clk = ~i_core_clk;

    // Reference enable; period 4 versus 1 mimics the two rate jumper settings
    always @(negedge i_core_clk)
    begin
        ref_cnt <= (ref_cnt + 1 >= ref_per) ? 0 : ref_cnt + 1;
        i_ref_clk_en <= (ref_cnt == 0);
    end

    // Hang guard, well above the longest expected run
    always @(posedge i_core_clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 80000)
        begin
            err_count++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        i_addr = a;
        i_wdata = d;
        i_wr = 1'b1;
        @(negedge i_core_clk);
        i_wr = 1'b0;
    endtask

    // Read data lands one edge after the strobe is taken
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        i_addr = a;
        i_rd = 1'b1;
        @(negedge i_core_clk);
        i_rd = 1'b0;
        @(negedge i_core_clk);
        d = o_rdata;
    endtask

    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask

    // Poll a status bit under a bounded count
    task automatic wait_lsr(input int n);
        logic [7:0] d;
        for (int k = 0; k < 4000; k++)
        begin
            rd(3'h5, d);
            if (d[n])
                break;
        end
        chk(d[n], 1'b1);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------
    // Sequence: all lengths, both stop counts, both modes and rates
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h5bcd_d05a));
        repeat (3) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        rdc(3'h3, 8'h00);
        rdc(3'h2, 8'h01);
        rdc(3'h6, 8'h00);
        wait_lsr(5);
        for (int c = 0; c < 8; c++)
        begin
            nb = 5 + c % 4;
            stops = 1 + c / 4;
            m485 = c[1] ^ c[2];
            ref_per = (c[0] ^ c[1]) ? 4 : 1;
            div = $urandom_range(2, 1);
            mask = 8'hff >> (8 - nb);
            i_mode_rs485 = m485;
            remote_node_inst.bit_cyc = 32 * div * ref_per;
            remote_node_inst.nbits = nb;
            wr(3'h3, 8'h80);
            wr(3'h0, div[7:0]);
            wr(3'h1, 8'h00);
            rdc(3'h0, div[7:0]);
            rdc(3'h1, 8'h00);
            // Odd and even parity both ways over half the passes
            par = c[0] ^ c[2];
            pev = c[1];
            remote_node_inst.par_on = par;
            remote_node_inst.par_even = pev;
            lcr = {3'h0, pev[0], par[0], stops == 2, 2'(nb - 5)};
            wr(3'h3, lcr);
            rdc(3'h3, lcr);
            mcr = {4'h0, c[0], 1'b0, !m485, 1'b0};
            wr(3'h4, mcr);
            chk(o_rts, !m485);
            rd(3'h0, v);
            rd(3'h0, v);
            // Two frames back to back through the buffer
            n0 = remote_node_inst.got.size();
            b0 = 8'($urandom);
            b1 = 8'($urandom);
            wait_lsr(5);
            wr(3'h0, b0);
            wait_lsr(5);
            wr(3'h0, b1);
            for (int k = 0; k < 20000 && remote_node_inst.got.size() < n0 + 2; k++)
                @(negedge i_core_clk);
            chk(remote_node_inst.got.size(), n0 + 2);
            chk(remote_node_inst.got[n0], b0 & mask);
            chk(remote_node_inst.got[n0 + 1], b1 & mask);
            gap = remote_node_inst.start_at[n0 + 1] - remote_node_inst.start_at[n0];
            gap -= remote_node_inst.bit_cyc * (1 + nb + par + stops);
            chk(gap >= 0 && gap <= 2 * div * ref_per, 1'b1);
            repeat (remote_node_inst.bit_cyc * 3) @(negedge i_core_clk);
            chk(o_drv_en, !m485);
            wr(3'h4, mcr & 8'hfd);
            chk(o_drv_en, 1'b0);
            // One frame inbound, flag, cause and data
            rb = 8'($urandom) & mask;
            remote_node_inst.send(rb, stops);
            wait_lsr(0);
            chk(o_irq, c[0]);
            rdc(3'h2, 8'h04);
            rdc(3'h0, rb);
            rd(3'h5, v);
            chk(v[0], 1'b0);
            rdc(3'h2, 8'h01);
        end
        chk(remote_node_inst.bad_stop, 0);
        chk(remote_node_inst.bad_par, 0);
        print_verdict();
    end
endmodule
